//--- rtl/rs232_pwr_host.sv
// Host-side power-mode controller driving the transceiver control pins
`timescale 1ns/10ps
`include "rs232_pwr_map.svh"
module rs232_pwr_host #(
    parameter int         READY_CYCLES = `READY_CYC,
    parameter int         WAKE_CYCLES  = `WAKE_PULSE_CYC,
    parameter logic [2:0] TX_USED_MASK = `TX_USED_MASK_RST
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] mode_sel,
    input  wire logic       sw_shutdown_req,
    input  wire logic [2:0] tx_data,
    input  wire logic [2:0] dev_rx_out,
    input  wire logic       dev_line_valid,
    output logic            dev_shutdown_n,
    output logic            dev_keep_awake,
    output logic [2:0]      dev_tx_in,
    output logic [2:0]      rx_data,
    output logic            line_valid,
    output logic            link_ready
);
    localparam int CW = $clog2(READY_CYCLES + 1) + 1;

    ////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    pin_sync_if #(.W(4)) pins ();

    pin_sync #(.W(4)) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_q),
        .raw     ({dev_line_valid, dev_rx_out}),
        .sync    (pins.src)
    );

    wire       inv_s = pins.level[3];
    wire [2:0] rx_s  = pins.level[2:0];

    ////////////////////////////////////////////////////////////////////
    // Mode decode
    rs232_pwr_pkg::pwr_mode_t   mode;
    rs232_pwr_pkg::pwr_state_t  state_q;
    rs232_pwr_pkg::pwr_state_t  state_d;
    logic [CW-1:0]              cnt_q;
    logic [CW-1:0]              cnt_d;

    function automatic logic want_power(
        input rs232_pwr_pkg::pwr_mode_t m,
        input logic                     req,
        input logic                     inv
    );
        case (m)
            rs232_pwr_pkg::MODE_ALWAYS_ON:   want_power = 1'b1;
            rs232_pwr_pkg::MODE_LINE_FOLLOW: want_power = inv;
            default:                         want_power = ~req;
        endcase
    endfunction

    assign mode = rs232_pwr_pkg::pwr_mode_t'(mode_sel);

    wire want_on  = want_power(mode, sw_shutdown_req, inv_s);
    wire is_auto  = (mode == rs232_pwr_pkg::MODE_AUTO);
    wire cnt_done = (cnt_q == '0);

    ////////////////////////////////////////////////////////////////////
    // Power sequence: wake pulse in auto mode only, then settle wait before the link is used
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (!cnt_done) begin
            cnt_d = cnt_q - 1'b1;
        end
        case (state_q)
            rs232_pwr_pkg::ST_OFF: begin
                if (want_on && is_auto) begin
                    state_d = rs232_pwr_pkg::ST_WAKE;
                    cnt_d   = CW'(WAKE_CYCLES - 1);
                end else if (want_on) begin
                    state_d = rs232_pwr_pkg::ST_SETTLE;
                    cnt_d   = CW'(READY_CYCLES - 1);
                end
            end
            rs232_pwr_pkg::ST_WAKE: begin
                if (cnt_done) begin
                    state_d = rs232_pwr_pkg::ST_SETTLE;
                    cnt_d   = CW'(READY_CYCLES - WAKE_CYCLES - 1);
                end
            end
            rs232_pwr_pkg::ST_SETTLE: begin
                if (cnt_done) begin
                    state_d = rs232_pwr_pkg::ST_READY;
                end
            end
            rs232_pwr_pkg::ST_READY: begin
                state_d = rs232_pwr_pkg::ST_READY;
            end
            default: begin
                state_d = rs232_pwr_pkg::ST_OFF;
            end
        endcase
        if (!want_on) begin
            state_d = rs232_pwr_pkg::ST_OFF;
            cnt_d   = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control pin levels
    logic shut_n_d;
    logic awake_d;

    always_comb begin
        case (mode)
            rs232_pwr_pkg::MODE_ALWAYS_ON: begin
                shut_n_d = 1'b1;
                awake_d  = 1'b1;
            end
            rs232_pwr_pkg::MODE_MANUAL: begin
                shut_n_d = want_on;
                awake_d  = want_on;
            end
            rs232_pwr_pkg::MODE_AUTO: begin
                shut_n_d = want_on;
                awake_d  = (state_d == rs232_pwr_pkg::ST_WAKE);
            end
            rs232_pwr_pkg::MODE_LINE_FOLLOW: begin
                shut_n_d = inv_s;
                awake_d  = inv_s;
            end
            default: begin
                shut_n_d = 1'b0;
                awake_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q        <= rs232_pwr_pkg::ST_OFF;
            cnt_q          <= '0;
            dev_shutdown_n <= 1'b0;
            dev_keep_awake <= 1'b0;
        end else begin
            state_q        <= state_d;
            cnt_q          <= cnt_d;
            dev_shutdown_n <= shut_n_d;
            dev_keep_awake <= awake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data pins
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dev_tx_in  <= '0;
            rx_data    <= '0;
            line_valid <= 1'b0;
        end else begin
            dev_tx_in  <= tx_data & TX_USED_MASK;
            rx_data    <= rx_s;
            line_valid <= inv_s;
        end
    end

    assign link_ready = (state_q == rs232_pwr_pkg::ST_READY);

    ////////////////////////////////////////////////////////////////////
    // Checks
    logic [CW-1:0] on_cnt_q;

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            on_cnt_q <= '0;
        end else if (!dev_shutdown_n) begin
            on_cnt_q <= '0;
        end else if (on_cnt_q != '1) begin
            on_cnt_q <= on_cnt_q + 1'b1;
        end
    end

    property p_tx_unused_low;
        @(posedge sys_clk) disable iff (!rst_n_q)
        (dev_tx_in & ~TX_USED_MASK) == 3'h0;
    endproperty
    a_tx_unused_low: assert property (p_tx_unused_low)
        else $error("unused transmitter input driven high");

    property p_line_follow;
        @(posedge sys_clk) disable iff (!rst_n_q)
        ##1 ($past(mode) == rs232_pwr_pkg::MODE_LINE_FOLLOW) |->
            (dev_shutdown_n == $past(inv_s)) &&
            (dev_keep_awake == $past(inv_s));
    endproperty
    a_line_follow: assert property (p_line_follow)
        else $error("control pins do not follow line indicator");

    property p_manual_tied;
        @(posedge sys_clk) disable iff (!rst_n_q)
        ##1 ($past(mode) == rs232_pwr_pkg::MODE_MANUAL) |->
            (dev_shutdown_n == dev_keep_awake) &&
            (dev_shutdown_n == !$past(sw_shutdown_req));
    endproperty
    a_manual_tied: assert property (p_manual_tied)
        else $error("manual control pins not tied together");

    property p_auto_request;
        @(posedge sys_clk) disable iff (!rst_n_q)
        ##1 ($past(mode) == rs232_pwr_pkg::MODE_AUTO) |->
            dev_shutdown_n == !$past(sw_shutdown_req);
    endproperty
    a_auto_request: assert property (p_auto_request)
        else $error("shutdown pin does not follow host request");

    property p_wake_pulse;
        @(posedge sys_clk) disable iff (!rst_n_q)
        ($rose(dev_shutdown_n) && is_auto && $stable(mode)) |->
            dev_keep_awake;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("no wake pulse on power up in auto mode");

    property p_ready_after_settle;
        @(posedge sys_clk) disable iff (!rst_n_q)
        $rose(link_ready) |-> (on_cnt_q >= CW'(READY_CYCLES - 1));
    endproperty
    a_ready_after_settle: assert property (p_ready_after_settle)
        else $error("link ready before settle time");
endmodule

//--- inc/rs232_pwr_map.svh
// Constants for the transceiver power-mode host controller
// Behaviour
// - Line-follow mode drives the line indicator onto both control inputs.
// - Single manual control drives both control inputs with one level.
// - Host switches power modes by shutdown_n_in; keep_awake_in secondary.
// - Unused transmitter inputs are driven low, never left floating.
`ifndef RS232_PWR_MAP_SVH
`define RS232_PWR_MAP_SVH

`define CLK_FREQ_MHZ      250
`define READY_TIME_US     100
`define READY_CYC         (`READY_TIME_US * `CLK_FREQ_MHZ)
`define WAKE_PULSE_NS     1000
`define WAKE_PULSE_CYC    ((`WAKE_PULSE_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define TX_COUNT          3
`define RX_COUNT          3
`define TX_USED_MASK_RST  3'h7

`endif

//--- inc/rs232_pwr_pkg.sv
// Types for the transceiver power-mode host controller
package rs232_pwr_pkg;

    typedef enum logic [1:0] {
        MODE_ALWAYS_ON   = 2'h0,
        MODE_MANUAL      = 2'h1,
        MODE_AUTO        = 2'h2,
        MODE_LINE_FOLLOW = 2'h3
    } pwr_mode_t;

    typedef enum logic [3:0] {
        ST_OFF    = 4'h1,
        ST_WAKE   = 4'h2,
        ST_SETTLE = 4'h4,
        ST_READY  = 4'h8
    } pwr_state_t;

endpackage

//--- inc/pin_sync_if.sv
// Synchronised device pin levels passed from the synchroniser to the core
`timescale 1ns/10ps
interface pin_sync_if #(
    parameter int W = 4
);
    logic [W-1:0] level;

    modport src (output level);
    modport dst (input  level);
endinterface

//--- rtl/pin_sync.sv
// Two-flop synchroniser bank for device pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] raw,
    pin_sync_if.src           sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            stable_q <= '0;
        end else begin
            meta_q   <= raw;
            stable_q <= meta_q;
        end
    end

    assign sync.level = stable_q;
endmodule

//--- test/dev_model.sv
// Behavioural transceiver model for the power-mode controller bench
`timescale 1ns/10ps
module dev_model #(
    parameter int AUTO_CYC = 200,
    parameter int BAD_CYC  = 30
) (
    input  wire logic       clk,
    input  wire logic       shutdown_n_in,
    input  wire logic       keep_awake_in,
    input  wire logic [2:0] tx_in,
    input  wire logic [2:0] rx_line,
    input  wire logic [2:0] rx_ok,
    output wire logic [2:0] tx_line,
    output wire logic [2:0] rx_out,
    output wire logic       line_ok,
    output wire logic       pump_on
);
    logic [2:0] tx_p  = 3'h0;
    logic [2:0] rx_p  = 3'h0;
    logic       ka_p  = 1'b0;
    logic       exp_q = 1'b0;
    int         idle  = 0;
    int         bad   = 0;
    wire        act   = (tx_in != tx_p) || (rx_line != rx_p);
    // Indicator has no path into the power decision
    assign pump_on = shutdown_n_in
        && (keep_awake_in || !exp_q);
    assign tx_line = pump_on ? ~tx_in : 3'hZ;
    assign rx_out  = ~rx_line;
    assign line_ok = (bad <= BAD_CYC);
    always @(posedge clk) begin
        tx_p <= tx_in;
        rx_p <= rx_line;
        ka_p <= keep_awake_in;
        if (act || keep_awake_in) begin
            idle <= 0;
        end else if (idle < AUTO_CYC) begin
            idle <= idle + 1;
        end
        if (act || (keep_awake_in && !ka_p)) begin
            exp_q <= 1'b0;
        end else if (!shutdown_n_in || idle == AUTO_CYC - 1) begin
            exp_q <= 1'b1;
        end
        bad <= (rx_ok != 3'h0) ? 0 : ((bad > BAD_CYC) ? bad : bad + 1);
    end
endmodule

//--- test/tb.sv
// Self-checking bench for the transceiver power-mode host controller
`timescale 1ns/10ps
module tb;
    localparam int RDY  = 20;
    localparam int WK   = 4;
    localparam int AUTO = 200;
    localparam int BAD  = 30;
    logic       sys_clk  = 1'b0;
    logic       reset_n  = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    logic       sw_req   = 1'b0;
    logic [2:0] tx_data  = 3'h0;
    logic [2:0] rx_line  = 3'h0;
    logic [2:0] rx_ok    = 3'h7;
    wire  [2:0] dev_rx_out, dev_tx_in, rx_data, tx_line;
    wire        dev_line_valid, sn, ka, line_valid, link_ready, pump_on;
    int         bad_count = 0;
    int         n_tests   = 0;
    always #2 sys_clk = ~sys_clk;
    rs232_pwr_host #(.READY_CYCLES(RDY), .WAKE_CYCLES(WK),
        .TX_USED_MASK(3'h5)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .mode_sel(mode_sel), .sw_shutdown_req(sw_req), .tx_data(tx_data),
        .dev_rx_out(dev_rx_out), .dev_line_valid(dev_line_valid),
        .dev_shutdown_n(sn), .dev_keep_awake(ka), .dev_tx_in(dev_tx_in),
        .rx_data(rx_data), .line_valid(line_valid), .link_ready(link_ready));
    dev_model #(.AUTO_CYC(AUTO), .BAD_CYC(BAD)) dev (.clk(sys_clk),
        .shutdown_n_in(sn), .keep_awake_in(ka), .tx_in(dev_tx_in),
        .rx_line(rx_line), .rx_ok(rx_ok), .tx_line(tx_line),
        .rx_out(dev_rx_out), .line_ok(dev_line_valid), .pump_on(pump_on));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic ready_in;
        int c;
        c = 0;
        while (link_ready !== 1'b1 && c < RDY + 10) begin
            tick(1);
            c++;
        end
        check(8'(c >= RDY && c <= RDY + 2), 8'h01);
    endtask
    task automatic report_and_stop;
        $display("tests=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_always_on;
        sw_req = 1'b1;
        tick(RDY + 5);
        check({sn, ka, link_ready, pump_on}, 8'h0F);
    endtask
    task automatic t_manual;
        mode_sel = 2'h1;
        tick(1);
        check({sn, ka, link_ready}, 8'h00);
        check(tx_line, 3'hZ);
        check(rx_data, {5'h00, ~rx_line});
        sw_req = 1'b0;
        ready_in;
        check({sn, ka, pump_on}, 8'h07);
    endtask
    task automatic t_auto;
        mode_sel = 2'h2;
        sw_req = 1'b1;
        tick(1);
        check({sn, pump_on}, 8'h00);
        sw_req = 1'b0;
        tick(1);
        check({sn, ka}, 8'h03);
        tick(WK - 1);
        check(ka, 1'b1);
        tick(1);
        check({sn, ka}, 8'h02);
        tick(AUTO - 10);
        check(pump_on, 1'b1);
        tick(20);
        check(tx_line, 3'hZ);
        tx_data = 3'h1;
        tick(2);
        check(tx_line, {5'h00, ~(3'h1 & 3'h5)});
    endtask
    task automatic t_line;
        mode_sel = 2'h3;
        tick(5);
        check({sn, ka}, 8'h03);
        rx_ok = 3'h0;
        tick(BAD - 5);
        check({line_valid, sn}, 8'h03);
        tick(15);
        check({line_valid, sn, ka, pump_on}, 8'h00);
        rx_ok = 3'h2;
        tick(5);
        check({line_valid, sn, pump_on}, 8'h07);
    endtask
    task automatic t_data;
        mode_sel = 2'h0;
        for (int i = 0; i < 8; i++) begin
            tx_data = 3'(i);
            rx_line = 3'(i);
            tick(3);
            check(dev_tx_in, 3'(i) & 3'h5);
            check(tx_line, {5'h00, ~(3'(i) & 3'h5)});
            check(rx_data, {5'h00, ~3'(i)});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        check({sn, ka, link_ready, line_valid}, 8'h00);
        reset_n = 1'b1;
        tick(6);
        t_always_on;
        t_manual;
        t_auto;
        t_line;
        t_data;
        report_and_stop;
    end
    initial begin
        #20000;
        bad_count++;
        report_and_stop;
    end
endmodule
